// ===== btn_operator.sv
// Operator model: presses and releases the two panel buttons.
// Assumes the selector settles each level for SETTLE_CYC cycles.
`timescale 1ns/1ps
module btn_operator #(
   parameter int unsigned SETTLE_CYC = btn_sel_pkg::DEBOUNCE_CYC
) (
   input wire logic core_clk,
   output logic left_btn_b,
   output logic right_btn_b
);
   // Both buttons up at start
   initial begin
      left_btn_b = 1'b1;
      right_btn_b = 1'b1;
   end
   // One button to a level, with a short bounce, then held steady
   task automatic move(input bit right, input logic lvl);
      for (int i = 0; i < 3; i++) begin
         @(negedge core_clk);
         if (right) right_btn_b = lvl ^ i[0];
         else left_btn_b = lvl ^ i[0];
      end
      repeat (SETTLE_CYC + 8) @(negedge core_clk);
   endtask
   // Right press then release
   task automatic click();
      move(1'b1, 1'b0);
      move(1'b1, 1'b1);
   endtask
endmodule

// ===== btn_sel_pkg.sv
// Constants for the two-button reset and mode selector.
// Assumes a 50 MHz system clock.
package btn_sel_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   // Debounce settle time in microseconds, and its cycle count
   localparam int unsigned DEBOUNCE_US = 20_000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   // Indicator frame is one second; each flash slot is an eighth of it
   localparam int unsigned FRAME_MS = 1_000;
   localparam int unsigned SLOT_CYC = (FRAME_MS * (CLK_HZ / 1_000)) / 8;
   localparam int unsigned SLOTS = 8;
   // Restart request pulse width in cycles
   localparam int unsigned RESTART_PULSE_CYC = 4;
   // Default addresses loaded when no DHCP server is present
   localparam logic [31:0] DEF_ADDR_PORT0 = 32'hC0A8_A464;
   localparam logic [31:0] DEF_ADDR_PORT1 = 32'hC0A8_A564;
   // Selection counts
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FACTORY = 2'h1;
   localparam logic [1:0] SEL_HOLD = 2'h2;
   localparam logic [1:0] SEL_ADDR = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_SELECT, ST_ABORT} sel_state_t;
endpackage

// ===== button_reset_mode_selector.sv
// Two-button reset and mode selector: restart, factory init, run/hold
// toggle and address assignment, with a flashing count indicator.
// Assumes raw push-button pins (active low) and a 50 MHz system clock.
//
// Summary of operation
// - Right click with left released requests a full controller restart.
// - After restart, run or halt state is kept as before restart.
// - Left held: count right clicks, flash the count once per second.
// - Count three flashes thrice; left release applies address assignment.
// - Counter wraps after the fourth click back to a count of one.
// - Count one on left release: restart with factory initialisation.
// - Count two on left release: restart and toggle run/halt state.
// - Address mode: use DHCP if present, else the default addresses.
// - Right held while left released aborts the pending selection.
`timescale 1ns/1ps
// Settle and slot counts default to the hardware timing
module button_reset_mode_selector #(
   parameter int unsigned DEBOUNCE_CYC = btn_sel_pkg::DEBOUNCE_CYC,
   parameter int unsigned SLOT_CYC = btn_sel_pkg::SLOT_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic left_btn_b,
   input wire logic right_btn_b,
   input wire logic dhcp_present,
   input wire logic dhcp_done,
   input wire logic [31:0] dhcp_addr0,
   input wire logic [31:0] dhcp_addr1,
   output logic restart_req,
   output logic factory_init,
   output logic dhcp_req,
   output logic run_mode,
   output logic [31:0] addr_port0,
   output logic [31:0] addr_port1,
   output logic [1:0] sel_count,
   output logic force_led
);
   localparam int unsigned DB_W = $clog2(DEBOUNCE_CYC);
   localparam int unsigned SL_W = $clog2(SLOT_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Synchronise and debounce both buttons
   logic [1:0] raw_in;
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] db_q;
   logic [1:0] db_prev_q;
   assign raw_in = {~right_btn_b, ~left_btn_b};

   // Two-flop synchroniser
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_db
         logic [DB_W-1:0] cnt_q;
         wire differs = sync2_q[g] != db_q[g];
         wire settled = cnt_q == DB_W'(DEBOUNCE_CYC - 1);
         // Level must stand steady for the whole settle time
         always_ff @(posedge core_clk) begin
            if (!rst_b) begin
               cnt_q <= '0;
               db_q[g] <= 1'b0;
            end else if (!differs) begin
               cnt_q <= '0;
            end else if (settled) begin
               cnt_q <= '0;
               db_q[g] <= sync2_q[g];
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   endgenerate

   // Edge detection on debounced levels
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         db_prev_q <= 2'h0;
      end else begin
         db_prev_q <= db_q;
      end
   end

   wire left_held = db_q[0];
   wire right_held = db_q[1];
   wire left_rel = db_prev_q[0] & ~db_q[0];
   wire right_click = db_prev_q[1] & ~db_q[1];
   wire right_press = ~db_prev_q[1] & db_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Selection state machine and counter
   btn_sel_pkg::sel_state_t state_q;
   btn_sel_pkg::sel_state_t state_d;
   logic [1:0] count_q;
   logic [1:0] count_d;
   logic apply;
   logic plain_reset;
   logic abort_sel;
   logic skip_q;

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      apply = 1'b0;
      plain_reset = 1'b0;
      abort_sel = 1'b0;
      case (state_q)
         btn_sel_pkg::ST_IDLE: begin
            if (left_held) begin
               state_d = btn_sel_pkg::ST_SELECT;
               count_d = btn_sel_pkg::SEL_NONE;
            end else if (right_click && !skip_q) begin
               plain_reset = 1'b1;
            end
         end
         btn_sel_pkg::ST_SELECT: begin
            if (right_press) begin
               state_d = btn_sel_pkg::ST_ABORT;
            end else if (left_rel) begin
               state_d = btn_sel_pkg::ST_IDLE;
               apply = count_q != btn_sel_pkg::SEL_NONE;
               count_d = btn_sel_pkg::SEL_NONE;
            end
         end
         btn_sel_pkg::ST_ABORT: begin
            // Click completes: count; left released while held: abort
            if (left_rel && right_held) begin
               state_d = btn_sel_pkg::ST_IDLE;
               abort_sel = 1'b1;
               count_d = btn_sel_pkg::SEL_NONE;
            end else if (right_click) begin
               state_d = btn_sel_pkg::ST_SELECT;
               // Fourth click wraps to one
               count_d = (count_q == btn_sel_pkg::SEL_ADDR) ?
                  btn_sel_pkg::SEL_FACTORY : count_q + 2'h1;
            end else if (!left_held) begin
               state_d = btn_sel_pkg::ST_IDLE;
               count_d = btn_sel_pkg::SEL_NONE;
            end
         end
         default: begin
            state_d = btn_sel_pkg::ST_IDLE;
            count_d = btn_sel_pkg::SEL_NONE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_q <= btn_sel_pkg::ST_IDLE;
         count_q <= btn_sel_pkg::SEL_NONE;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end
   assign sel_count = count_q;

   // Right release that ends an abort must not restart
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         skip_q <= 1'b0;
      end else if (abort_sel) begin
         skip_q <= 1'b1;
      end else if (!right_held) begin
         skip_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Actions: restart pulse, factory init, run/halt, address assignment
   wire do_factory = apply && count_q == btn_sel_pkg::SEL_FACTORY;
   wire do_toggle = apply && count_q == btn_sel_pkg::SEL_HOLD;
   wire do_addr = apply && count_q == btn_sel_pkg::SEL_ADDR;
   wire any_restart = plain_reset | do_factory | do_toggle | do_addr;
   logic [2:0] rst_cnt_q;
   logic run_q;
   logic fact_q;
   logic dhcp_q;
   logic [31:0] a0_q;
   logic [31:0] a1_q;

   // Restart request held a few cycles; run state survives it
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rst_cnt_q <= 3'h0;
         run_q <= 1'b1;
         fact_q <= 1'b0;
      end else begin
         if (any_restart) begin
            rst_cnt_q <= 3'(btn_sel_pkg::RESTART_PULSE_CYC);
            fact_q <= do_factory;
         end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
         end
         if (do_toggle) begin
            run_q <= ~run_q;
         end
      end
   end
   assign restart_req = rst_cnt_q != 3'h0;
   assign factory_init = fact_q & restart_req;
   assign run_mode = run_q;

   // Address assignment: DHCP when present, defaults otherwise
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         dhcp_q <= 1'b0;
         a0_q <= btn_sel_pkg::DEF_ADDR_PORT0;
         a1_q <= btn_sel_pkg::DEF_ADDR_PORT1;
      end else if (do_addr) begin
         dhcp_q <= dhcp_present;
         if (!dhcp_present) begin
            a0_q <= btn_sel_pkg::DEF_ADDR_PORT0;
            a1_q <= btn_sel_pkg::DEF_ADDR_PORT1;
         end
      end else if (dhcp_q && dhcp_done) begin
         dhcp_q <= 1'b0;
         a0_q <= dhcp_addr0;
         a1_q <= dhcp_addr1;
      end
   end
   assign dhcp_req = dhcp_q;
   assign addr_port0 = a0_q;
   assign addr_port1 = a1_q;

   ////////////////////////////////////////////////////////////////////////
   // Indicator: one-second frame of eight slots, flash on even slots
   logic [SL_W-1:0] slot_cyc_q;
   logic [2:0] slot_q;
   logic led_q;
   wire slot_end = slot_cyc_q == SL_W'(SLOT_CYC - 1);
   wire [2:0] flash_idx = {1'b0, slot_q[2:1]};
   wire flash_on = ~slot_q[0] && flash_idx < {1'b0, count_q};

   always_ff @(posedge core_clk) begin
      if (!rst_b || count_d == btn_sel_pkg::SEL_NONE) begin
         slot_cyc_q <= '0;
         slot_q <= 3'h0;
         led_q <= 1'b0;
      end else begin
         slot_cyc_q <= slot_end ? '0 : slot_cyc_q + 1'b1;
         if (slot_end) begin
            slot_q <= slot_q + 3'h1;
         end
         led_q <= flash_on;
      end
   end
   assign force_led = led_q;
endmodule

// ===== button_reset_mode_selector_assertions.sv
// Checker for the selector outputs.
// Assumes binding to the selector top, one clock, sync reset.
`timescale 1ns/1ps
module button_reset_mode_selector_assertions (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic dhcp_done,
   input wire logic [31:0] dhcp_addr0,
   input wire logic [31:0] dhcp_addr1,
   input wire logic restart_req,
   input wire logic factory_init,
   input wire logic dhcp_req,
   input wire logic run_mode,
   input wire logic [31:0] addr_port0,
   input wire logic [31:0] addr_port1,
   input wire logic [1:0] sel_count,
   input wire logic force_led
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // Restart pulse shape and companions
   property p_pulse;
      $rose(restart_req) |-> restart_req [*4] ##1 !restart_req;
   endproperty
   a_pulse: assert property (p_pulse) else $error("bad pulse");
   property p_factory;
      factory_init |-> restart_req;
   endproperty
   a_factory: assert property (p_factory) else $error("lone init");
   property p_fsel;
      $rose(restart_req) |-> factory_init == ($past(sel_count) == 2'h1);
   endproperty
   a_fsel: assert property (p_fsel) else $error("init mismatch");
   property p_toggle;
      $changed(run_mode) |-> $rose(restart_req);
   endproperty
   a_toggle: assert property (p_toggle) else $error("bad run");
   property p_clear;
      $rose(restart_req) |-> sel_count == 2'h0 && !force_led;
   endproperty
   a_clear: assert property (p_clear) else $error("no clear");
   // Click count steps, and indicator dark at a count of zero
   property p_wrap;
      $changed(sel_count) && sel_count != 2'h0 |->
         sel_count == $past(sel_count) + 2'h1 ||
         ($past(sel_count) == 2'h3 && sel_count == 2'h1);
   endproperty
   a_wrap: assert property (p_wrap) else $error("bad count");
   property p_led;
      sel_count == 2'h0 |-> !force_led;
   endproperty
   a_led: assert property (p_led) else $error("led lit");
   // Address request handshake
   property p_dhold;
      dhcp_req && !dhcp_done |=> dhcp_req;
   endproperty
   a_dhold: assert property (p_dhold) else $error("req drop");
   property p_dtake;
      dhcp_req && dhcp_done |=> !dhcp_req &&
         addr_port0 == $past(dhcp_addr0) && addr_port1 == $past(dhcp_addr1);
   endproperty
   a_dtake: assert property (p_dtake) else $error("no take");
endmodule

// ===== button_reset_mode_selector_tb_top.sv
// Testbench for the selector, driven through the operator model.
// Assumes short settle and slot counts, set by the localparams below.
`timescale 1ns/1ps
module button_reset_mode_selector_tb_top;
   logic core_clk, rst_b, dhcp_present, dhcp_done, rr_q, fi_q;
   logic [31:0] dhcp_addr0, dhcp_addr1, addr_port0, addr_port1;
   logic left_btn_b, right_btn_b, restart_req, factory_init, dhcp_req;
   logic run_mode, force_led;
   logic [1:0] sel_count;
   int miscompares = 0, total_checks = 0, restarts = 0, factories = 0;
   int base;
   int flashes = 0;
   logic fl_q;
   // Shortened timing keeps the run brief
   localparam int unsigned DB_CYC = 100;
   localparam int unsigned SL_CYC = 16;
   btn_operator #(.SETTLE_CYC(DB_CYC)) i_op (.core_clk(core_clk),
      .left_btn_b(left_btn_b), .right_btn_b(right_btn_b));
   button_reset_mode_selector #(.DEBOUNCE_CYC(DB_CYC), .SLOT_CYC(SL_CYC))
      i_dut (.core_clk(core_clk), .rst_b(rst_b),
      .left_btn_b(left_btn_b), .right_btn_b(right_btn_b),
      .dhcp_present(dhcp_present), .dhcp_done(dhcp_done),
      .dhcp_addr0(dhcp_addr0), .dhcp_addr1(dhcp_addr1),
      .restart_req(restart_req), .factory_init(factory_init),
      .dhcp_req(dhcp_req), .run_mode(run_mode), .addr_port0(addr_port0),
      .addr_port1(addr_port1), .sel_count(sel_count), .force_led(force_led));
   ////////////////////////////////////////////////////////////////////////
   // Clock, pulse counters, watchdog
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      rr_q <= restart_req;
      fi_q <= factory_init;
      fl_q <= force_led;
      if (force_led === 1'b1 && fl_q !== 1'b1) flashes++;
      if (restart_req === 1'b1 && rr_q !== 1'b1) restarts++;
      if (factory_init === 1'b1 && fi_q !== 1'b1) factories++;
   end
   initial begin
      repeat (20_000) @(posedge core_clk);
      miscompares++;
      conclude();
   end
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Count indicator flashes over exactly one frame
   task automatic frame();
      flashes = 0;
      repeat (btn_sel_pkg::SLOTS * SL_CYC) @(negedge core_clk);
   endtask
   task automatic select(input int n);
      i_op.move(1'b0, 1'b0);
      repeat (n) i_op.click();
   endtask
   task automatic conclude();
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      rst_b = 1'b0;
      dhcp_present = 1'b0;
      dhcp_done = 1'b0;
      dhcp_addr0 = 32'h0A00_0001;
      dhcp_addr1 = 32'h0A00_0002;
      repeat (16) @(negedge core_clk);
      rst_b = 1'b1;
      chk("run_mode", 1'b1, run_mode);
      chk("addr_port0", btn_sel_pkg::DEF_ADDR_PORT0, addr_port0);
      chk("sel_count", 2'h0, sel_count);
      i_op.click();
      chk("restarts", 1, restarts);
      chk("factories", 0, factories);
      select(2);
      chk("sel_count", 2'h2, sel_count);
      frame();
      chk("flashes", 2, flashes);
      i_op.move(1'b0, 1'b1);
      chk("run_mode", 1'b0, run_mode);
      i_op.click();
      chk("run_mode", 1'b0, run_mode);
      chk("restarts", 3, restarts);
      select(4);
      chk("sel_count", 2'h1, sel_count);
      frame();
      chk("flashes", 1, flashes);
      i_op.move(1'b0, 1'b1);
      chk("factories", 1, factories);
      chk("run_mode", 1'b0, run_mode);
      chk("force_led", 1'b0, force_led);
      dhcp_present = 1'b1;
      select(3);
      chk("sel_count", 2'h3, sel_count);
      frame();
      chk("flashes", 3, flashes);
      i_op.move(1'b0, 1'b1);
      chk("dhcp_req", 1'b1, dhcp_req);
      dhcp_done = 1'b1;
      @(negedge core_clk);
      dhcp_done = 1'b0;
      chk("addr_port1", dhcp_addr1, addr_port1);
      chk("addr_port0", dhcp_addr0, addr_port0);
      dhcp_present = 1'b0;
      select(3);
      i_op.move(1'b0, 1'b1);
      chk("addr_port0", btn_sel_pkg::DEF_ADDR_PORT0, addr_port0);
      chk("addr_port1", btn_sel_pkg::DEF_ADDR_PORT1, addr_port1);
      base = restarts;
      select(1);
      i_op.move(1'b1, 1'b0);
      i_op.move(1'b0, 1'b1);
      i_op.move(1'b1, 1'b1);
      chk("sel_count", 2'h0, sel_count);
      chk("restarts", base, restarts);
      chk("factories", 1, factories);
      conclude();
   end
endmodule
bind button_reset_mode_selector button_reset_mode_selector_assertions i_chk (
   .core_clk(core_clk), .rst_b(rst_b), .dhcp_done(dhcp_done),
   .dhcp_addr0(dhcp_addr0), .dhcp_addr1(dhcp_addr1),
   .restart_req(restart_req), .factory_init(factory_init),
   .dhcp_req(dhcp_req), .run_mode(run_mode), .addr_port0(addr_port0),
   .addr_port1(addr_port1), .sel_count(sel_count), .force_led(force_led));
